//--- rtl/bgum_regs.vh
`ifndef BGUM_REGS_VH
`define BGUM_REGS_VH
// Register byte offsets
`define BGUM_CTRL_OFS 8'h00
`define BGUM_BDATA_OFS 8'h04
`define BGUM_FPTR_OFS 8'h08
`define BGUM_STAT_OFS 8'h0C
// Control register fields
`define BGUM_CM_LSB 0
`define BGUM_CM_MSB 2
`define BGUM_MULTI_BIT 5
`define BGUM_LEV_LSB 6
`define BGUM_LEV_MSB 8
`define BGUM_CTRL_RST 9'h000
// Burst buffer geometry
`define BGUM_BUF_BITS 160
`define BGUM_BUF_WORDS 4'hA
`define BGUM_LAST_BIT 8'h9F
// Modulator
`define BGUM_INTERP 16
`define BGUM_WIN_BITS 4
`define BGUM_TAIL_QBITS 32
`define BGUM_TAIL_SAMPLES (`BGUM_TAIL_QBITS * `BGUM_INTERP / 4)
`define BGUM_I_MAX 10'h1FF
// Sample rate: 4.33 MHz from the 10 MHz clock by a fractional accumulator
`define BGUM_CLK_KHZ 10000
`define BGUM_SAMPLE_KHZ 4330
// Power-on settling delay
`define BGUM_SETTLE_NS 5000
`define BGUM_CLK_NS 100
`define BGUM_SETTLE_CYC ((`BGUM_SETTLE_NS + `BGUM_CLK_NS - 1) / `BGUM_CLK_NS)
// Sized forms of the counts above, at the width of the logic that uses them
`define BGUM_SETTLE_LAST 8'h32
`define BGUM_SAMPLE_INC 14'h10EA
`define BGUM_CLK_MOD 14'h2710
`define BGUM_TAIL_LAST 7'h7F
`endif

//--- rtl/bgum_modulator.v
`include "bgum_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module bgum_modulator (
  input wire hclk, // Master clock
  input wire hresetn, // Asynchronous reset, active low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response
  input wire tsp_enable, // Timing serial port enable
  input wire tsp_data, // Timing serial port data
  input wire cmp_i, // I output offset comparator, high when positive
  input wire cmp_q, // Q output offset comparator, high when positive
  output reg [9:0] i_word, // I converter word, two's complement
  output reg [9:0] q_word, // Q converter word, two's complement
  output reg sample_strobe, // Pulse per converter sample
  output reg [5:0] i_offset, // I sub-converter code
  output reg [5:0] q_offset, // Q sub-converter code
  output wire [2:0] output_level_sel, // Output level select
  output wire [2:0] common_mode_sel, // Common-mode select
  output reg path_powered, // Uplink path in power-on mode
  output reg mod_active // Modulation running
);
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg [8:0] ctrl;
  reg [159:0] buf0;
  reg [159:0] buf1;
  reg [3:0] fill_ptr;
  reg rd_sel;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg tx_power_window;
  reg tx_calibrate_window;
  reg tx_modulate_window;
  reg [31:0] rd_val;
  wire addr_ok = hsel & hready & htrans[1];
  wire multi_burst_select = ctrl[`BGUM_MULTI_BIT];
  wire fill_sel = multi_burst_select ? ~rd_sel : 1'b0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign output_level_sel = ctrl[`BGUM_LEV_MSB:`BGUM_LEV_LSB];
  assign common_mode_sel = ctrl[`BGUM_CM_MSB:`BGUM_CM_LSB];
  always @* begin
    case (haddr[7:0])
      `BGUM_CTRL_OFS: rd_val = {23'h000000, ctrl};
      `BGUM_FPTR_OFS: rd_val = {27'h0000000, fill_sel, fill_ptr};
      `BGUM_STAT_OFS: rd_val = {12'h000, i_offset, q_offset, rd_sel,
        tx_power_window, tx_calibrate_window, tx_modulate_window,
        path_powered, mod_active, 2'h0};
      default: rd_val = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_val;
      end
    end
  end
  // ----------------------------------------
  // Timing port, settling and sample clock
  // ----------------------------------------
  reg tsp_phase;
  reg tsp_en_d;
  reg [2:0] tsp_shift;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsp_phase <= 1'b0;
      tsp_en_d <= 1'b0;
      tsp_shift <= 3'h0;
      tx_power_window <= 1'b0;
      tx_calibrate_window <= 1'b0;
      tx_modulate_window <= 1'b0;
    end else begin
      tsp_phase <= ~tsp_phase;
      if (tsp_phase) begin
        tsp_en_d <= tsp_enable;
        if (tsp_enable) begin
          tsp_shift <= {tsp_shift[1:0], tsp_data};
        end
        if (tsp_en_d & ~tsp_enable) begin
          tx_power_window <= tsp_shift[2];
          tx_calibrate_window <= tsp_shift[1];
          tx_modulate_window <= tsp_shift[0];
        end
      end
    end
  end
  reg [7:0] settle_cnt;
  reg [13:0] rate_acc;
  wire [13:0] rate_sum = rate_acc + `BGUM_SAMPLE_INC;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= 8'h00;
      path_powered <= 1'b0;
      rate_acc <= 14'h0000;
      sample_strobe <= 1'b0;
    end else begin
      if (!tx_power_window) begin
        settle_cnt <= 8'h00;
        path_powered <= 1'b0;
      end else if (settle_cnt == `BGUM_SETTLE_LAST) begin
        path_powered <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 8'h01;
      end
      if (rate_sum >= `BGUM_CLK_MOD) begin
        rate_acc <= rate_sum - `BGUM_CLK_MOD;
        sample_strobe <= 1'b1;
      end else begin
        rate_acc <= rate_sum;
        sample_strobe <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Modulator and sine table
  // ----------------------------------------
  function [9:0] qsin;
    input [4:0] k;
    begin
      case (k)
        5'h00: qsin = 10'h000;
        5'h01: qsin = 10'h032;
        5'h02: qsin = 10'h064;
        5'h03: qsin = 10'h094;
        5'h04: qsin = 10'h0C4;
        5'h05: qsin = 10'h0F1;
        5'h06: qsin = 10'h11C;
        5'h07: qsin = 10'h145;
        5'h08: qsin = 10'h169;
        5'h09: qsin = 10'h18B;
        5'h0A: qsin = 10'h1A9;
        5'h0B: qsin = 10'h1C3;
        5'h0C: qsin = 10'h1D8;
        5'h0D: qsin = 10'h1E9;
        5'h0E: qsin = 10'h1F5;
        5'h0F: qsin = 10'h1FD;
        default: qsin = `BGUM_I_MAX;
      endcase
    end
  endfunction
  function [9:0] fsin;
    input [5:0] p;
    reg [4:0] k;
    begin
      k = {1'b0, p[3:0]};
      case (p[5:4])
        2'h0: fsin = qsin(k);
        2'h1: fsin = qsin(5'h10 - k);
        2'h2: fsin = 10'h000 - qsin(k);
        default: fsin = 10'h000 - qsin(5'h10 - k);
      endcase
    end
  endfunction
  reg [7:0] bit_ptr;
  reg [3:0] samp_idx;
  reg [3:0] window;
  reg [9:0] phase;
  reg [6:0] tail_cnt;
  reg in_tail;
  reg mod_win_d;
  wire [5:0] step = (window[0] ? 6'h02 : 6'h3E) + (window[1] ? 6'h06 : 6'h3A) +
    (window[2] ? 6'h06 : 6'h3A) + (window[3] ? 6'h02 : 6'h3E);
  wire next_bit;
  wire [159:0] rd_buf;
  wire [5:0] cos_idx;
  wire mod_end;
  assign rd_buf = (multi_burst_select & rd_sel) ? buf1 : buf0;
  assign next_bit = (bit_ptr <= `BGUM_LAST_BIT) ? rd_buf[bit_ptr] : 1'b0;
  assign cos_idx = phase[9:4] + 6'h10;
  assign mod_end = mod_active & in_tail & sample_strobe &
    (tail_cnt == `BGUM_TAIL_LAST);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_active <= 1'b0;
      mod_win_d <= 1'b0;
      in_tail <= 1'b0;
      tail_cnt <= 7'h00;
      bit_ptr <= 8'h00;
      samp_idx <= 4'h0;
      window <= 4'h0;
      phase <= 10'h000;
      rd_sel <= 1'b0;
      i_word <= `BGUM_I_MAX;
      q_word <= 10'h000;
      i_offset <= 6'h20;
      q_offset <= 6'h20;
    end else begin
      mod_win_d <= tx_modulate_window;
      if (tx_modulate_window & ~mod_win_d & path_powered & ~mod_active) begin
        mod_active <= 1'b1;
        in_tail <= 1'b0;
        tail_cnt <= 7'h00;
      end
      if (mod_active & ~tx_modulate_window) begin
        in_tail <= 1'b1;
      end
      if (mod_active & sample_strobe) begin
        samp_idx <= samp_idx + 4'h1;
        if (samp_idx == 4'hF) begin
          window <= {window[2:0], next_bit};
          if (bit_ptr <= `BGUM_LAST_BIT) begin
            bit_ptr <= bit_ptr + 8'h01;
          end
        end
        phase <= phase + {{4{step[5]}}, step};
        i_word <= fsin(cos_idx);
        q_word <= fsin(phase[9:4]);
        if (in_tail | ~tx_modulate_window) begin
          tail_cnt <= tail_cnt + 7'h01;
        end
      end
      if (mod_end) begin
        mod_active <= 1'b0;
        in_tail <= 1'b0;
        bit_ptr <= 8'h00;
        samp_idx <= 4'h0;
        window <= 4'h0;
        phase <= 10'h000;
        i_word <= `BGUM_I_MAX;
        q_word <= 10'h000;
        if (multi_burst_select) begin
          rd_sel <= ~rd_sel;
        end
      end
      if (tx_calibrate_window & path_powered & ~mod_active) begin
        i_word <= 10'h000;
        q_word <= 10'h000;
        if (sample_strobe) begin
          if (cmp_i & (i_offset != 6'h00)) begin
            i_offset <= i_offset - 6'h01;
          end else if (~cmp_i & (i_offset != 6'h3F)) begin
            i_offset <= i_offset + 6'h01;
          end
          if (cmp_q & (q_offset != 6'h00)) begin
            q_offset <= q_offset - 6'h01;
          end else if (~cmp_q & (q_offset != 6'h3F)) begin
            q_offset <= q_offset + 6'h01;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // Register writes and burst loading
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `BGUM_CTRL_RST;
      fill_ptr <= 4'h0;
      buf0 <= 160'h0;
      buf1 <= 160'h0;
    end else begin
      if (mod_end & multi_burst_select) begin
        fill_ptr <= 4'h0;
      end
      if (wr_pend) begin
        case (wr_addr)
          `BGUM_CTRL_OFS: ctrl <= hwdata[8:0];
          `BGUM_FPTR_OFS: fill_ptr <= hwdata[3:0];
          `BGUM_BDATA_OFS: begin
            if (fill_ptr < `BGUM_BUF_WORDS) begin
              if (fill_sel) begin
                buf1[fill_ptr * 16 +: 16] <= hwdata[15:0];
              end else begin
                buf0[fill_ptr * 16 +: 16] <= hwdata[15:0];
              end
              fill_ptr <= fill_ptr + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- test/bgum_modulator_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bgum_modulator_sva (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hreadyout, // Ready
  input wire logic hresp, // Response
  input wire logic [9:0] i_word, // I word
  input wire logic [9:0] q_word, // Q word
  input wire logic sample_strobe, // Strobe
  input wire logic [5:0] i_offset, // I offset
  input wire logic [5:0] q_offset, // Q offset
  input wire logic [2:0] output_level_sel, // Level
  input wire logic [2:0] common_mode_sel, // Common mode
  input wire logic path_powered, // Powered
  input wire logic mod_active // Modulating
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic ctl_wr;
  assign ctl_wr = hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
  // One code apart, wrap counts as a miss
  function automatic logic step1(input logic [5:0] a, input logic [5:0] b);
    return ({1'h0, a} == {1'h0, b} + 7'h01) || ({1'h0, b} == {1'h0, a} + 7'h01);
  endfunction
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_pulse; sample_strobe |=> !sample_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe wider than one cycle");
  property p_gap; hresetn && !sample_strobe ##1 !sample_strobe |-> ##[1:2] sample_strobe;
  endproperty
  a_gap: assert property (p_gap) else $error("strobe gap too long");
  property p_istep; $changed(i_offset) |-> step1(i_offset, $past(i_offset)); endproperty
  a_istep: assert property (p_istep) else $error("I offset jumped");
  property p_qstep; $changed(q_offset) |-> step1(q_offset, $past(q_offset)); endproperty
  a_qstep: assert property (p_qstep) else $error("Q offset jumped");
  property p_cal; $changed(i_offset) || $changed(q_offset) |-> path_powered && !mod_active;
  endproperty
  a_cal: assert property (p_cal) else $error("offset moved outside calibration");
  property p_reinit; $fell(mod_active) |-> ##[0:1] (i_word == 10'h1FF && q_word == 10'h000);
  endproperty
  a_reinit: assert property (p_reinit) else $error("words not reset after burst");
  property p_ctrl; $past(ctl_wr, 2) |-> output_level_sel == $past(hwdata[8:6])
    && common_mode_sel == $past(hwdata[2:0]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control fields not taken");
  c_start: cover property ($rose(mod_active));
  c_end: cover property ($fell(mod_active));
  c_cal: cover property ($changed(i_offset));
endmodule
bind bgum_modulator bgum_modulator_sva bgum_modulator_sva_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .i_word(i_word), .q_word(q_word),
  .sample_strobe(sample_strobe), .i_offset(i_offset), .q_offset(q_offset),
  .output_level_sel(output_level_sel), .common_mode_sel(common_mode_sel),
  .path_powered(path_powered), .mod_active(mod_active));
`default_nettype wire

//--- test/bgum_tp_model.sv
`timescale 1ns/1ps
`default_nettype none
module bgum_tp_model #(
  parameter logic [5:0] tgt_i = 6'h2A,
  parameter logic [5:0] tgt_q = 6'h15
) (
  input wire logic hclk, // Clock
  input wire logic send, // Frame request
  input wire logic [2:0] win, // Power, cal, mod
  output logic busy, // Frame running
  output logic tsp_enable = 1'h0, // Port enable
  output logic tsp_data = 1'h0, // Port data
  input wire logic [5:0] i_offset, // I code
  input wire logic [5:0] q_offset, // Q code
  output logic cmp_i, // I positive
  output logic cmp_q // Q positive
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] sh = 3'h0;
  assign busy = cnt != 3'h0;
  assign cmp_i = i_offset > tgt_i;
  assign cmp_q = q_offset > tgt_q;
  // three window bits, two clocks each
  always @(posedge hclk) begin
    if (send && cnt == 3'h0) begin
      cnt <= 3'h6;
      sh <= {win[1:0], 1'h0};
      tsp_enable <= 1'h1;
      tsp_data <= win[2];
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        tsp_enable <= 1'h0;
        tsp_data <= ~tsp_data;
      end else if (cnt[0]) begin
        tsp_data <= sh[2];
        sh <= {sh[1:0], 1'h0};
      end
    end
  end
endmodule
`default_nettype wire

//--- test/burst_gmsk_uplink_modulator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module burst_gmsk_uplink_modulator_bench;
  logic hclk, hresetn, hsel, hwrite, send, moved;
  logic [31:0] haddr, hwdata, rd_data;
  logic [1:0] htrans;
  logic [2:0] hsize, win;
  wire logic hreadyout, hresp, sample_strobe, path_powered, mod_active, busy;
  wire logic tsp_enable, tsp_data, cmp_i, cmp_q;
  wire logic [31:0] hrdata;
  wire logic [9:0] i_word, q_word;
  wire logic [5:0] i_offset, q_offset;
  wire logic [2:0] output_level_sel, common_mode_sel;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int since = 0;
  int tail = 0;
  int n;
  bgum_modulator bgum_modulator_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tsp_enable(tsp_enable),
    .tsp_data(tsp_data), .cmp_i(cmp_i), .cmp_q(cmp_q), .i_word(i_word), .q_word(q_word),
    .sample_strobe(sample_strobe), .i_offset(i_offset), .q_offset(q_offset),
    .output_level_sel(output_level_sel), .common_mode_sel(common_mode_sel),
    .path_powered(path_powered), .mod_active(mod_active));
  bgum_tp_model bgum_tp_model_i (.hclk(hclk), .send(send), .win(win), .busy(busy),
    .tsp_enable(tsp_enable), .tsp_data(tsp_data), .i_offset(i_offset), .q_offset(q_offset),
    .cmp_i(cmp_i), .cmp_q(cmp_q));
  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cycles and modulated strobes since the last frame ended
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    since <= busy ? 0 : since + 1;
    tail <= busy ? 0 : tail + (sample_strobe && mod_active);
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd_data = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'h0, a, 32'h00000000);
    chk(rd_data & m, e);
  endtask
  task automatic frame(input logic [2:0] w);
    win <= w;
    send <= 1'h1;
    @(posedge hclk);
    send <= 1'h0;
    @(posedge hclk);
    while (busy === 1'h1) @(posedge hclk);
    n = 0;
    do begin
      xfer(1'h0, 8'h0C, 32'h00000000);
      n++;
    end while (rd_data[6:4] !== w && n < 8);
    chk(rd_data[6:4], w);
  endtask
  task automatic burst(input logic [3:0] ptr, input logic sel);
    frame(3'h5);
    chk(mod_active, 1'h1);
    xfer(1'h1, 8'h04, 32'h00005AA5);
    rchk(8'h08, 32'h0000000F, {28'h0000000, ptr});
    frame(3'h4);
    moved = 1'h0;
    n = 0;
    while (mod_active === 1'h1 && n < 3000) begin
      @(posedge hclk);
      n++;
      moved = moved | (q_word !== 10'h000);
    end
    chk(tail >= 126 && tail <= 130, 1'h1);
    @(posedge hclk);
    chk({i_word, q_word}, {10'h1FF, 10'h000});
    chk(moved, 1'h1);
    rchk(8'h0C, 32'h00000080, {24'h000000, sel, 7'h00});
  endtask
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    send = 1'h0;
    win = 3'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({i_word, q_word, i_offset, q_offset}, {10'h1FF, 10'h000, 6'h20, 6'h20});
    rchk(8'h00, 32'hFFFFFFFF, 32'h00000000);
    rchk(8'h10, 32'hFFFFFFFF, 32'h00000000);
    $display("reset test done");
    xfer(1'h1, 8'h00, 32'h000001E5);
    rchk(8'h00, 32'hFFFFFFFF, 32'h000001E5);
    chk({output_level_sel, common_mode_sel}, 6'h3D);
    xfer(1'h1, 8'h00, 32'h000000D2);
    rchk(8'h00, 32'hFFFFFFFF, 32'h000000D2);
    chk({output_level_sel, common_mode_sel}, 6'h1A);
    $display("control test done");
    for (int k = 0; k < 11; k++) xfer(1'h1, 8'h04, 32'h0000A5C3 + k);
    rchk(8'h08, 32'h0000000F, 32'h0000000A);
    frame(3'h4);
    chk(path_powered, 1'h0);
    n = 0;
    while (path_powered !== 1'h1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk(since >= 50 && since <= 55, 1'h1);
    $display("power test done");
    frame(3'h6);
    repeat (400) @(posedge hclk);
    chk({i_word, q_word}, 20'h00000);
    chk(i_offset >= 6'h29 && i_offset <= 6'h2B, 1'h1);
    chk(q_offset >= 6'h14 && q_offset <= 6'h16, 1'h1);
    frame(3'h4);
    $display("calibration test done");
    burst(4'hA, 1'h0);
    $display("single slot test done");
    xfer(1'h1, 8'h00, 32'h000001E5);
    burst(4'hA, 1'h1);
    rchk(8'h08, 32'h0000000F, 32'h00000000);
    burst(4'h1, 1'h0);
    $display("multislot test done");
    stop_test();
  end
endmodule
`default_nettype wire
